// ===== pkg/cai_defines.vh
/*
 constants for the per-channel alarm interrupt logic: register offsets,
 field positions, reset values. assumes inclusion by bare name.
*/
`ifndef CAI_DEFINES_VH
`define CAI_DEFINES_VH
`define CAI_OFS_ENABLE 4'h1
`define CAI_OFS_STATUS 4'h2
`define CAI_BIT_DRIVE 0
`define CAI_BIT_SIGNAL 1
`define CAI_BIT_LOCK 2
`define CAI_BIT_FIFO 3
`define CAI_NUM_SRC 4
`define CAI_ENABLE_RESET 4'h0
`define CAI_STATUS_RESET 4'h0
`define CAI_CHAN_PER_BANK 6
`define CAI_BANK_BIT 7
`define CAI_SETTLE_COUNT 2'h3
`endif

// ===== src/cai_channel.v
/*
 one channel: edge detection of four alarm levels, sticky status flags
 cleared on read, enable register and channel interrupt request.
 assumes alarm levels already synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "cai_defines.vh"
module cai_channel
(
  input wire ref_clk,
  input wire rst,
  input wire [3:0] alarm_level,
  input wire enable_write,
  input wire [7:0] write_data,
  input wire status_read,
  output reg [3:0] channel_irq_enable,
  output reg [3:0] channel_irq_status,
  output wire channel_irq
);
  reg [3:0] alarm_prev;
  reg [1:0] settle;
  wire primed;
  wire [3:0] change_event;
  // wait until both sync stages and alarm_prev hold real levels, else a false change fires
  assign primed = (settle == `CAI_SETTLE_COUNT);
  assign change_event = primed ? (alarm_level ^ alarm_prev) : 4'h0;
  genvar i;
  generate
    for (i = 0; i < `CAI_NUM_SRC; i = i + 1)
    begin : g_src
      always @(posedge ref_clk)
      begin
        if (rst)
          channel_irq_status[i] <= 1'b0;
        // both edges, gated by enable; set wins over read clear
        else if (change_event[i] && channel_irq_enable[i])
          channel_irq_status[i] <= 1'b1;
        else if (status_read)
          channel_irq_status[i] <= 1'b0;
      end
    end
  endgenerate
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      alarm_prev <= 4'h0;
      settle <= 2'h0;
      channel_irq_enable <= `CAI_ENABLE_RESET;
    end
    else
    begin
      alarm_prev <= alarm_level;
      if (!primed)
        settle <= settle + 2'h1;
      if (enable_write)
        channel_irq_enable <= write_data[3:0];
    end
  end
  assign channel_irq = |(channel_irq_status & channel_irq_enable);
endmodule

// ===== src/cai_top.v
/*
 twelve-channel alarm change interrupt source logic behind the parallel
 microprocessor port: per-channel enable and clear-on-read status
 registers, two-stage synchronisers for the alarm levels, address decode
 and a registered read-back path.
 register map: the high address nibble selects the row, rows 0-5 are
 channels 0-5 and rows 8-d are channels 6-11; low nibble 1 is the enable
 register and low nibble 2 the status register; all else reads zero.
 an event that meets a status read in the same cycle keeps its flag set.
 clearing an enable drops the request but leaves the flag for software.
 the first three cycles after reset only capture the alarm baseline.
 assumes a synchronous one-cycle read and write strobe from the port
 decoder, and alarm levels from asynchronous sources that hold each
 level for at least three ref_clk cycles.
*/

//
// Contract
// - enabled signal loss declaration raises an interrupt event.
// - enabled signal loss clearing also raises an interrupt event.
// - enable bit 1 gates the signal loss change interrupt.
// - enabled drive monitor rise or fall raises an interrupt event.
// - enable bit 0 gates the drive monitor change interrupt.
// - status holds fifo, lock, signal, drive flags in bits 3..0; 7..4 reserved.
// - enable bit 3 gates fifo limit alarm change events.
// - enable bit 2 gates lock loss change events.
// - flag reads 1 after its event, clears as a side effect of read.
`timescale 1ns/1ps
`include "cai_defines.vh"

module cai_top
#(
  parameter CHANNELS = 12
)
(
  input wire ref_clk,
  input wire rst,
  input wire [7:0] addr,
  input wire read_strobe,
  input wire write_strobe,
  input wire [7:0] write_data,
  output reg [7:0] read_data,
  input wire [CHANNELS-1:0] signal_loss_defect,
  input wire [CHANNELS-1:0] drive_monitor_flag,
  input wire [CHANNELS-1:0] lock_loss_defect,
  input wire [CHANNELS-1:0] fifo_limit_alarm,
  output wire [CHANNELS-1:0] channel_irq
);
  localparam SOURCES = `CAI_NUM_SRC;
  localparam [3:0] BANK_ROWS = `CAI_CHAN_PER_BANK;
  localparam [4:0] BANK_OFFSET = `CAI_CHAN_PER_BANK;

  // alarm pins as one word per source, drive monitor lowest
  wire [SOURCES*CHANNELS-1:0] alarm_raw;
  reg [SOURCES*CHANNELS-1:0] sync_a;
  reg [SOURCES*CHANNELS-1:0] sync_b;

  // address decode
  wire [3:0] row;
  wire [3:0] reg_sel;
  wire bank_hi;
  wire [4:0] row_base;
  wire [4:0] chan_idx;
  wire row_ok;
  wire chan_ok;
  wire sel_enable;
  wire sel_status;

  // per-channel strobes and read-back
  wire [CHANNELS-1:0] chan_hit;
  wire [CHANNELS-1:0] chan_enable_write;
  wire [CHANNELS-1:0] chan_status_read;
  wire [SOURCES*(CHANNELS+1)-1:0] ena_chain;
  wire [SOURCES*(CHANNELS+1)-1:0] sts_chain;
  wire [SOURCES-1:0] ena_pick;
  wire [SOURCES-1:0] sts_pick;
  reg [7:0] next_read_data;

  genvar b;
  genvar c;

  assign alarm_raw = {fifo_limit_alarm, lock_loss_defect,
                      signal_loss_defect, drive_monitor_flag};

  // two stages per bit: the detectors run on their own line clocks
  generate
    for (b = 0; b < SOURCES*CHANNELS; b = b + 1)
    begin : g_sync
      always @(posedge ref_clk)
      begin
        if (rst)
        begin
          sync_a[b] <= 1'b0;
          sync_b[b] <= 1'b0;
        end
        else
        begin
          sync_a[b] <= alarm_raw[b];
          sync_b[b] <= sync_a[b];
        end
      end
    end
  endgenerate

  // channel index from row and bank
  // rows 6 and 7 of each bank map to no channel and read zero
  assign row = addr[7:4];
  assign reg_sel = addr[3:0];
  assign bank_hi = addr[`CAI_BANK_BIT];
  assign row_base = {2'b00, row[2:0]};
  assign row_ok = {1'b0, row[2:0]} < BANK_ROWS;
  assign chan_idx = bank_hi ? row_base + BANK_OFFSET : row_base;
  assign chan_ok = row_ok && (chan_idx < CHANNELS);

  assign sel_enable = reg_sel == `CAI_OFS_ENABLE;
  assign sel_status = reg_sel == `CAI_OFS_STATUS;

  // the chains start empty and pick up the one selected channel
  assign ena_chain[SOURCES-1:0] = {SOURCES{1'b0}};
  assign sts_chain[SOURCES-1:0] = {SOURCES{1'b0}};

  generate
    for (c = 0; c < CHANNELS; c = c + 1)
    begin : g_ch
      wire [SOURCES-1:0] level;
      wire [SOURCES-1:0] chan_ena;
      wire [SOURCES-1:0] chan_sts;

      assign chan_hit[c] = chan_ok && (chan_idx == c);

      // status writes are ignored: its flags only clear on read
      assign chan_enable_write[c] = write_strobe && chan_hit[c] && sel_enable;
      assign chan_status_read[c] = read_strobe && chan_hit[c] && sel_status;

      // an event needs three edges: two sync stages and one compare
      assign level[`CAI_BIT_DRIVE] = sync_b[c];
      assign level[`CAI_BIT_SIGNAL] = sync_b[CHANNELS+c];
      assign level[`CAI_BIT_LOCK] = sync_b[2*CHANNELS+c];
      assign level[`CAI_BIT_FIFO] = sync_b[3*CHANNELS+c];

      cai_channel u_ch
      (
        .ref_clk(ref_clk),
        .rst(rst),
        .alarm_level(level),
        .enable_write(chan_enable_write[c]),
        .write_data(write_data),
        .status_read(chan_status_read[c]),
        .channel_irq_enable(chan_ena),
        .channel_irq_status(chan_sts),
        .channel_irq(channel_irq[c])
      );

      // one-hot select, so an and-or chain stands in for a wide mux
      assign ena_chain[SOURCES*(c+1)+:SOURCES] = ena_chain[SOURCES*c+:SOURCES]
                                                 | (chan_ena & {SOURCES{chan_hit[c]}});
      assign sts_chain[SOURCES*(c+1)+:SOURCES] = sts_chain[SOURCES*c+:SOURCES]
                                                 | (chan_sts & {SOURCES{chan_hit[c]}});
    end
  endgenerate

  assign ena_pick = ena_chain[SOURCES*CHANNELS+:SOURCES];
  assign sts_pick = sts_chain[SOURCES*CHANNELS+:SOURCES];

  // reserved upper bits and unmapped addresses read zero
  always @*
  begin
    next_read_data = 8'h00;
    if (chan_ok)
    begin
      case (reg_sel)
        `CAI_OFS_ENABLE:
        begin
          next_read_data = {4'h0, ena_pick};
        end
        `CAI_OFS_STATUS:
        begin
          next_read_data = {4'h0, sts_pick};
        end
        default:
        begin
          next_read_data = 8'h00;
        end
      endcase
    end
  end

  // a snapshot: the flags clear on the same edge that captures them,
  // so read_data holds the value from before the clear
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      read_data <= 8'h00;
    end
    else if (read_strobe)
    begin
      read_data <= next_read_data;
    end
  end

endmodule

// ===== verification/cai_asserts.sv
/* port checker for cai_top, watching channel 0. assumes bind by port names. */
`timescale 1ns/1ps
module cai_asserts #(parameter CHANNELS = 12) (
  input wire ref_clk, input wire rst, input wire [7:0] addr, input wire read_strobe,
  input wire write_strobe, input wire [7:0] write_data, input wire [7:0] read_data,
  input wire [CHANNELS-1:0] signal_loss_defect, input wire [CHANNELS-1:0] drive_monitor_flag,
  input wire [CHANNELS-1:0] lock_loss_defect, input wire [CHANNELS-1:0] fifo_limit_alarm,
  input wire [CHANNELS-1:0] channel_irq);
  wire [3:0] al = {fifo_limit_alarm[0], lock_loss_defect[0], signal_loss_defect[0],
    drive_monitor_flag[0]};
  reg [3:0] al_q;
  reg [3:0] quiet;
  // quiet saturates so a settled channel needs no wide counter
  always @(posedge ref_clk)
  begin
    al_q <= al;
    quiet <= (rst || al != al_q) ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  resv_zero_a: assert property (read_strobe |=> read_data[7:4] == 4'h0)
    else $error("reserved bits set");
  enable_rw_a: assert property (write_strobe && addr == 8'h01 ##1 read_strobe &&
    addr == 8'h01 |=> read_data[3:0] == $past(write_data[3:0], 2)) else $error("bad enable");
  irq_drop_a: assert property (write_strobe && addr == 8'h01 &&
    write_data[3:0] == 4'h0 |=> !channel_irq[0]) else $error("irq not dropped");
  read_hold_a: assert property (!read_strobe |=> $stable(read_data))
    else $error("read data moved");
  irq_hold_a: assert property (channel_irq[0] && !read_strobe && !$past(read_strobe) &&
    !write_strobe |=> channel_irq[0]) else $error("irq lost");
  flag_read_a: assert property (read_strobe && addr == 8'h02 && channel_irq[0]
    |=> read_data[3:0] != 4'h0) else $error("flag missing");
  clr_read_a: assert property (read_strobe && addr == 8'h02 && quiet > 4'h7
    |-> ##2 !channel_irq[0]) else $error("flag not cleared");
  irq_cause_a: assert property ($rose(channel_irq[0]) |-> quiet < 4'h8 ||
    $past(write_strobe)) else $error("irq without cause");
endmodule
bind cai_top cai_asserts #(.CHANNELS(CHANNELS)) cai_asserts_inst (.*);

// ===== verification/testbench.sv
/* register-level bench for cai_top. assumes all channels see the same alarms. */
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 0, rst = 1, rs = 0, ws = 0;
  reg [7:0] addr = 8'h00, wd = 8'h00;
  reg [3:0] al = 4'h0;
  wire [7:0] rdat;
  wire [11:0] irq;
  integer n_mismatch = 0, cmp_count = 0, cyc = 0, i;
  always #5 ref_clk = ~ref_clk;
  cai_top cai_top_inst (.ref_clk(ref_clk), .rst(rst), .addr(addr), .read_strobe(rs),
    .write_strobe(ws), .write_data(wd), .read_data(rdat), .signal_loss_defect({12{al[1]}}),
    .drive_monitor_flag({12{al[0]}}), .lock_loss_defect({12{al[2]}}),
    .fifo_limit_alarm({12{al[3]}}), .channel_irq(irq));
  task check(input [63:0] nm, input [11:0] seen, input [11:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // both tasks start and end on a falling edge
  task wr(input [7:0] a, input [7:0] d);
  begin
    {addr, wd, ws} = {a, d, 1'b1};
    @(negedge ref_clk) ws = 0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    {addr, rs} = {a, 1'b1};
    @(negedge ref_clk) rs = 0;
    @(negedge ref_clk) check("reg", {4'h0, rdat}, {4'h0, e});
  end
  endtask
  task wrap_up;
  begin
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 0;
    rd(8'h01, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h0f);
    // first four passes raise each alarm, the next four lower it
    for (i = 0; i < 8; i = i + 1)
    begin
      al[i%4] = ~al[i%4];
      repeat (10) @(negedge ref_clk);
      check("irq", irq, 12'h001);
      rd(8'h02, 8'h01 << (i%4));
      check("irq", irq, 12'h000);
    end
    $display("edge test done");
    wr(8'hd1, 8'h01);
    al[0] = ~al[0];
    repeat (10) @(negedge ref_clk);
    check("irq", irq, 12'h801);
    rd(8'hd2, 8'h01);
    rd(8'h02, 8'h01);
    wr(8'hd1, 8'h00);
    $display("bank test done");
    al[1] = ~al[1];
    repeat (10) @(negedge ref_clk);
    wr(8'h01, 8'h00);
    check("irq", irq, 12'h000);
    rd(8'h02, 8'h02);
    al = ~al;
    repeat (10) @(negedge ref_clk);
    rd(8'h02, 8'h00);
    rd(8'h0f, 8'h00);
    $display("gate test done");
    wrap_up;
  end
endmodule
